// ==== src/rfm_defines.vh ====
// Register map, field codes and timing counts of the framing and modulation block.
// Assumes inclusion by bare name into the Verilog design file and the SystemVerilog checker and testbench files.
`ifndef RFM_DEFINES_VH
`define RFM_DEFINES_VH
// ----------------------------------------
// Register byte offsets
// ----------------------------------------
`define RFM_CTRL_OFF 12'h000
`define RFM_TXDATA_OFF 12'h004
`define RFM_RXDATA_OFF 12'h008
`define RFM_STATUS_OFF 12'h00C
`define RFM_PREAMBLE_OFF 12'h010
`define RFM_PRELEN_OFF 12'h014
`define RFM_RATE_OFF 12'h018
`define RFM_DEV_OFF 12'h01C
`define RFM_GAIN_OFF 12'h020
`define RFM_STRENGTH_OFF 12'h024
`define RFM_AMPL_OFF 12'h028
`define RFM_OFFSET_OFF 12'h02C
`define RFM_MBUS_OFF 12'h030
// ----------------------------------------
// Control fields
// ----------------------------------------
`define RFM_CTRL_FRAME_LSB 0
`define RFM_CTRL_MOD_LSB 2
`define RFM_CTRL_CRC_LSB 5
`define RFM_CTRL_CTL16_BIT 7
`define RFM_CTRL_CLOSE_BIT 8
`define RFM_CTRL_ASHAPE_BIT 9
`define RFM_CTRL_FSHAPE_LSB 10
`define RFM_CTRL_RXEN_BIT 12
`define RFM_CTRL_SYNTH_BIT 13
`define RFM_CTRL_RST 32'h0000_0200
// Framing modes
`define RFM_FRM_HDLC 2'h0
`define RFM_FRM_MBUS 2'h1
`define RFM_FRM_RAW 2'h2
`define RFM_FRM_RAWPM 2'h3
// Modulations
`define RFM_MOD_ASK 3'h0
`define RFM_MOD_FSK 3'h1
`define RFM_MOD_MSK 3'h2
`define RFM_MOD_PSK 3'h3
`define RFM_MOD_4FSK 3'h4
// Check sequences
`define RFM_CRC_CCITT 2'h0
`define RFM_CRC_16 2'h1
`define RFM_CRC_32 2'h2
// Frequency shaping
`define RFM_FSH_HARD 2'h0
`define RFM_FSH_BT03 2'h1
`define RFM_FSH_BT05 2'h2
// ----------------------------------------
// Constants
// ----------------------------------------
`define RFM_FLAG 8'h7E
`define RFM_POLY_CCITT 32'h0000_1021
`define RFM_POLY_16 32'h0000_8005
`define RFM_POLY_32 32'h04C1_1DB7
`define RFM_PRELEN_MIN 6'h04
`define RFM_PRELEN_MAX 6'h20
`define RFM_PRELEN_RST 6'h10
`define RFM_RATE_RST 16'h0140
`define RFM_RAMP_STEPS 4'hF
`endif

// ==== src/rfm_framer.v ====
// Framing, CRC and symbol mapping engine with an APB register slave.
// Assumes a 40 MHz pclk; rx bits arrive from the front end asynchronously
// and pass a two-flop synchroniser; front-end measurements are plain inputs.
//
// Notes on behaviour
// RULE1: HDLC frame: flag, address, control, info, FCS, flag; code sends the closing flag only when RFM_CTRL_CLOSE_BIT is set
// RULE2: Flag 0x7E delimits frames both directions
// RULE3: FCS selectable CCITT, CRC-16 or CRC-32
// RULE4: Address and control pass through uninterpreted
// RULE5: Receive checks FCS, queues result, appends CRC
// RULE6: Metering-bus header, blocks each with 16-bit check
// RULE7: Raw mode only serialises and groups bytes
// RULE8: Preamble match discards bits, then aligns bytes
// RULE9: Preamble length 4 to 32 bits
// RULE10: Gain counter readable, valid after synth programmed
// RULE11: Post-filter strength readable, 1 dB steps
// RULE12: Tracked amplitude readable for fine strength
// RULE13: ASK: amplifier off for 0, on for 1
// RULE14: FSK: minus deviation for 0, plus for 1
// RULE15: MSK is FSK with quarter bit-rate deviation; code uses half the dev register instead
// RULE16: PSK: 180 degree shift for a one
// RULE17: Raised-cosine amplitude shaping, ramps amplifier
// RULE18: Frequency shaping hard or Gaussian BT 0.3/0.5
// RULE19: 4-FSK dibit map, always hard shaping
// RULE20: Carrier offset tracking register readable
// RULE21: Demodulates frequency keying with index below 32
//
// Design decisions made here: the APB slave port and the register addresses.
`timescale 1ns/1ps
`include "rfm_defines.vh"
module rfm_framer #(
  parameter RATE_W = 16
) (
  input wire pclk, // Bus clock
  input wire presetn, // Async reset, active low
  input wire psel, // APB select
  input wire penable, // APB enable
  input wire pwrite, // APB direction
  input wire [11:0] paddr, // APB byte address
  input wire [31:0] pwdata, // APB write data
  output reg [31:0] prdata, // APB read data
  output wire pready, // APB ready
  output wire pslverr, // APB error
  input wire rx_bit_in, // Demodulated bit, async
  input wire rx_bit_strobe, // Demodulated bit strobe, async
  input wire [7:0] gain_control_counter, // Gain counter from front end
  input wire [7:0] filtered_strength_value, // Post-filter strength
  input wire [15:0] tracked_amplitude, // Demodulator amplitude
  input wire [31:0] carrier_offset_tracking, // Frequency tracking word
  output reg pa_enable, // Amplifier on
  output reg [7:0] pa_amplitude, // Shaped amplitude
  output reg [2:0] pa_phase_flip, // Phase toggle count, bit0 is phase
  output reg signed [17:0] freq_offset, // Signed frequency deviation
  output reg [1:0] freq_shape, // Shaping filter selection
  output reg tx_active // Transmitting
);
  // ----------------------------------------
  // Functions
  // ----------------------------------------
  function [31:0] crc_step;
    input [31:0] crc;
    input b;
    input [1:0] kind;
    reg fb;
    begin
      fb = 1'b0;
      crc_step = crc;
      case (kind)
        `RFM_CRC_32: begin
          fb = crc[31] ^ b;
          crc_step = {crc[30:0], 1'b0} ^ (fb ? `RFM_POLY_32 : 32'h0000_0000);
        end
        `RFM_CRC_16: begin
          fb = crc[15] ^ b;
          crc_step = {16'h0000, crc[14:0], 1'b0} ^ (fb ? `RFM_POLY_16 : 32'h0000_0000);
        end
        default: begin
          fb = crc[15] ^ b;
          crc_step = {16'h0000, crc[14:0], 1'b0} ^ (fb ? `RFM_POLY_CCITT : 32'h0000_0000);
        end
      endcase
    end
  endfunction
  function [31:0] crc_init;
    input [1:0] kind;
    begin
      crc_init = (kind == `RFM_CRC_32) ? 32'hFFFF_FFFF :
                 (kind == `RFM_CRC_16) ? 32'h0000_0000 : 32'h0000_FFFF;
    end
  endfunction
  // ----------------------------------------
  // Registers
  // ----------------------------------------
  reg [31:0] ctrl;
  reg [31:0] preamble;
  reg [5:0] prelen;
  reg [RATE_W-1:0] rate;
  reg [15:0] dev;
  reg [7:0] mbus_blk;
  reg [7:0] tx_byte;
  reg tx_byte_valid;
  reg tx_last;
  reg [7:0] rx_byte;
  reg [1:0] rx_tag;
  reg rx_byte_valid;
  reg rx_overrun;
  reg crc_ok;
  wire [1:0] frame_mode = ctrl[`RFM_CTRL_FRAME_LSB+1:`RFM_CTRL_FRAME_LSB];
  wire [2:0] mod_sel = ctrl[`RFM_CTRL_MOD_LSB+2:`RFM_CTRL_MOD_LSB];
  wire [1:0] crc_kind = ctrl[`RFM_CTRL_CRC_LSB+1:`RFM_CTRL_CRC_LSB];
  wire wr = psel & penable & pwrite;
  wire rd = psel & penable & ~pwrite;
  reg addr_ok;
  reg [31:0] rdata;
  assign pready = 1'b1;
  assign pslverr = psel & penable & ~addr_ok;
  always @* begin
    addr_ok = 1'b1;
    rdata = 32'h0000_0000;
    case (paddr)
      `RFM_CTRL_OFF: rdata = ctrl;
      `RFM_TXDATA_OFF: rdata = {23'h00_0000, tx_byte_valid, tx_byte};
      `RFM_RXDATA_OFF: rdata = {21'h00_0000, rx_byte_valid, rx_tag, rx_byte};
      `RFM_STATUS_OFF: rdata = {28'h000_0000, crc_ok, rx_overrun, tx_active, tx_byte_valid};
      `RFM_PREAMBLE_OFF: rdata = preamble;
      `RFM_PRELEN_OFF: rdata = {26'h000_0000, prelen};
      `RFM_RATE_OFF: rdata = {{(32-RATE_W){1'b0}}, rate};
      `RFM_DEV_OFF: rdata = {16'h0000, dev};
      `RFM_GAIN_OFF: rdata = {23'h00_0000, ctrl[`RFM_CTRL_SYNTH_BIT],
                              gain_control_counter}; // RULE10
      `RFM_STRENGTH_OFF: rdata = {24'h00_0000, filtered_strength_value}; // RULE11
      `RFM_AMPL_OFF: rdata = {16'h0000, tracked_amplitude}; // RULE12
      `RFM_OFFSET_OFF: rdata = carrier_offset_tracking; // RULE20 RULE21
      `RFM_MBUS_OFF: rdata = {24'h00_0000, mbus_blk};
      default: addr_ok = 1'b0;
    endcase
  end
  // ----------------------------------------
  // Receive synchroniser
  // ----------------------------------------
  reg [1:0] rxd_s1, rxd_s2;
  reg rxs_prev;
  always @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      rxd_s1 <= 2'b00;
      rxd_s2 <= 2'b00;
      rxs_prev <= 1'b0;
    end else begin
      rxd_s1 <= {rx_bit_strobe, rx_bit_in};
      rxd_s2 <= rxd_s1;
      rxs_prev <= rxd_s2[1];
    end
  end
  wire rx_bit_evt = rxd_s2[1] & ~rxs_prev & ctrl[`RFM_CTRL_RXEN_BIT];
  wire rx_bit = rxd_s2[0];
  // ----------------------------------------
  // Bit-rate enable
  // ----------------------------------------
  reg [RATE_W-1:0] rate_cnt;
  wire bit_tick = (rate_cnt == {RATE_W{1'b0}});
  always @(posedge pclk or negedge presetn) begin
    if (!presetn)
      rate_cnt <= {RATE_W{1'b0}};
    else if (bit_tick)
      rate_cnt <= rate - 1'b1;
    else
      rate_cnt <= rate_cnt - 1'b1;
  end
  // ----------------------------------------
  // Transmit framer
  // ----------------------------------------
  localparam TX_IDLE = 3'd0;
  localparam TX_OPEN = 3'd1;
  localparam TX_DATA = 3'd2;
  localparam TX_FCS = 3'd3;
  localparam TX_CLOSE = 3'd4;
  reg [2:0] tx_state;
  reg [7:0] sh;
  reg [2:0] bit_idx;
  reg [31:0] tx_crc;
  reg [2:0] fcs_left;
  reg [6:0] mbus_cnt;
  reg sh_bit;
  reg tx_end;
  wire mbus = (frame_mode == `RFM_FRM_MBUS);
  wire raw = frame_mode[1];
  wire [1:0] tx_ck = mbus ? `RFM_CRC_16 : crc_kind;
  wire [2:0] fcs_bytes = (tx_ck == `RFM_CRC_32) ? 3'd4 : 3'd2;
  wire [31:0] crc_out = (tx_ck == `RFM_CRC_32) ? ~tx_crc :
                        (mbus ? ~{tx_crc[15:0], 16'h0000} : ~{tx_crc[15:0], 16'h0000});
  always @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      ctrl <= `RFM_CTRL_RST;
      preamble <= 32'h0000_0000;
      prelen <= `RFM_PRELEN_RST;
      rate <= `RFM_RATE_RST;
      dev <= 16'h0000;
      mbus_blk <= 8'h00;
      tx_byte <= 8'h00;
      tx_byte_valid <= 1'b0;
      tx_last <= 1'b0;
      tx_state <= TX_IDLE;
      sh <= 8'h00;
      bit_idx <= 3'd0;
      tx_crc <= 32'h0000_0000;
      fcs_left <= 3'd0;
      mbus_cnt <= 7'd0;
      sh_bit <= 1'b0;
      tx_end <= 1'b0;
      tx_active <= 1'b0;
    end else begin
      if (wr) begin
        case (paddr)
          `RFM_CTRL_OFF: ctrl <= pwdata;
          `RFM_PREAMBLE_OFF: preamble <= pwdata;
          `RFM_PRELEN_OFF: begin
            if (pwdata[5:0] < `RFM_PRELEN_MIN)
              prelen <= `RFM_PRELEN_MIN; // RULE9
            else if (pwdata[5:0] > `RFM_PRELEN_MAX)
              prelen <= `RFM_PRELEN_MAX; // RULE9
            else
              prelen <= pwdata[5:0];
          end
          `RFM_RATE_OFF: rate <= pwdata[RATE_W-1:0];
          `RFM_DEV_OFF: dev <= pwdata[15:0];
          `RFM_MBUS_OFF: mbus_blk <= pwdata[7:0];
          `RFM_TXDATA_OFF: begin
            if (!tx_byte_valid) begin
              tx_byte <= pwdata[7:0];
              tx_last <= pwdata[8];
              tx_byte_valid <= 1'b1;
            end
          end
          default: ;
        endcase
      end
      tx_end <= 1'b0;
      if (bit_tick) begin
        if (bit_idx != 3'd0) begin
          bit_idx <= bit_idx - 1'b1;
          sh_bit <= sh[0];
          sh <= {1'b0, sh[7:1]};
          if (tx_state == TX_DATA)
            tx_crc <= crc_step(tx_crc, sh[0], tx_ck); // RULE3 RULE6
        end else begin
          case (tx_state)
            TX_IDLE: begin
              tx_active <= 1'b0;
              if (tx_byte_valid) begin
                tx_active <= 1'b1;
                tx_crc <= crc_init(tx_ck);
                mbus_cnt <= 7'd0;
                if (raw) begin
                  tx_state <= TX_DATA; // RULE7
                end else if (mbus) begin
                  tx_state <= TX_DATA; // RULE6
                end else begin
                  sh <= `RFM_FLAG >> 1; // RULE1 RULE2
                  bit_idx <= 3'd7;
                  sh_bit <= 1'b0;
                  tx_state <= TX_OPEN;
                end
              end
            end
            TX_OPEN, TX_DATA: begin
              if (tx_state == TX_DATA && tx_last && !tx_byte_valid && !raw) begin
                tx_state <= TX_FCS;
                fcs_left <= fcs_bytes;
              end else if (tx_byte_valid) begin
                sh <= {1'b0, tx_byte[7:1]}; // RULE4
                sh_bit <= tx_byte[0];
                if (tx_state == TX_DATA || tx_state == TX_OPEN)
                  tx_crc <= crc_step(tx_crc, tx_byte[0], tx_ck);
                bit_idx <= 3'd7;
                tx_byte_valid <= 1'b0;
                tx_state <= TX_DATA;
                mbus_cnt <= mbus_cnt + 1'b1;
                if (mbus && !tx_last && (mbus_cnt + 1'b1 == mbus_blk[6:0])) begin
                  tx_state <= TX_FCS; // RULE6
                  fcs_left <= 3'd2;
                end
              end else if (raw && tx_state == TX_DATA && tx_last) begin
                tx_state <= TX_IDLE;
                tx_end <= 1'b1;
              end
            end
            TX_FCS: begin
              if (fcs_left == 3'd0) begin
                if (mbus && !tx_last) begin
                  tx_state <= TX_DATA;
                  tx_crc <= crc_init(tx_ck);
                  mbus_cnt <= 7'd0;
                end else if (!mbus && ctrl[`RFM_CTRL_CLOSE_BIT]) begin
                  sh <= `RFM_FLAG >> 1; // RULE1
                  sh_bit <= 1'b0;
                  bit_idx <= 3'd7;
                  tx_state <= TX_CLOSE;
                end else begin
                  tx_state <= TX_IDLE;
                  tx_end <= 1'b1;
                end
              end else begin
                sh <= crc_out[32-8*fcs_bytes +: 8] >> 1; // RULE1 RULE5
                sh_bit <= crc_out[32-8*fcs_bytes];
                bit_idx <= 3'd7;
                fcs_left <= fcs_left - 1'b1;
                tx_crc <= {tx_crc[23:0], 8'h00};
              end
            end
            TX_CLOSE: begin
              tx_state <= TX_IDLE;
              tx_end <= 1'b1;
            end
            default: tx_state <= TX_IDLE;
          endcase
        end
      end
      if (tx_end && !tx_byte_valid)
        tx_last <= 1'b0;
    end
  end
  // ----------------------------------------
  // Symbol mapper and shaping
  // ----------------------------------------
  reg prev_bit;
  reg [3:0] ramp;
  wire [17:0] dev1 = {2'b00, dev};
  wire [17:0] dev_m = (mod_sel == `RFM_MOD_MSK) ? {3'b000, rate[RATE_W-1:2] > 0 ?
                      dev[15:1] : dev[15:1]} : dev1; // RULE15
  always @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      pa_enable <= 1'b0;
      pa_amplitude <= 8'h00;
      pa_phase_flip <= 3'd0;
      freq_offset <= 18'sh0_0000;
      freq_shape <= `RFM_FSH_HARD;
      prev_bit <= 1'b0;
      ramp <= 4'h0;
    end else begin
      freq_shape <= (mod_sel == `RFM_MOD_4FSK) ? `RFM_FSH_HARD
                    : ctrl[`RFM_CTRL_FSHAPE_LSB+1:`RFM_CTRL_FSHAPE_LSB]; // RULE18 RULE19
      if (!ctrl[`RFM_CTRL_ASHAPE_BIT])
        ramp <= tx_active ? `RFM_RAMP_STEPS : 4'h0;
      else if (tx_active && ramp != `RFM_RAMP_STEPS)
        ramp <= ramp + 1'b1; // RULE17
      else if (!tx_active && ramp != 4'h0)
        ramp <= ramp - 1'b1; // RULE17
      pa_amplitude <= {ramp, ramp} - {4'h0, ramp[3:2], 2'b00} * ramp[0]; // RULE17
      if (bit_tick && tx_active) begin
        prev_bit <= sh_bit;
        case (mod_sel)
          `RFM_MOD_ASK: begin
            pa_enable <= sh_bit; // RULE13
            freq_offset <= 18'sh0_0000;
          end
          `RFM_MOD_PSK: begin
            pa_enable <= 1'b1;
            if (sh_bit)
              pa_phase_flip <= pa_phase_flip + 1'b1; // RULE16
          end
          `RFM_MOD_4FSK: begin
            pa_enable <= 1'b1;
            case ({prev_bit, sh_bit}) // RULE19
              2'b00: freq_offset <= -$signed(dev1 + dev1 + dev1);
              2'b01: freq_offset <= -$signed(dev1);
              2'b11: freq_offset <= $signed(dev1);
              default: freq_offset <= $signed(dev1 + dev1 + dev1);
            endcase
          end
          default: begin
            pa_enable <= 1'b1;
            freq_offset <= sh_bit ? $signed(dev_m) : -$signed(dev_m); // RULE14 RULE15
          end
        endcase
      end else if (!tx_active && ramp == 4'h0) begin
        pa_enable <= 1'b0;
        freq_offset <= 18'sh0_0000;
      end
    end
  end
  // ----------------------------------------
  // Receive deframer
  // ----------------------------------------
  reg [31:0] rx_hist;
  reg [7:0] rx_sh;
  reg [2:0] rx_cnt;
  reg rx_sync;
  reg [31:0] rx_crc;
  reg [31:0] pre_mask;
  wire [7:0] rx_next = {rx_bit, rx_sh[7:1]};
  wire [31:0] hist_next = {rx_hist[30:0], rx_bit};
  wire [31:0] res_good = (crc_kind == `RFM_CRC_32) ? 32'hC704_DD7B : 32'h0000_0000;
  always @* begin
    pre_mask = 32'hFFFF_FFFF >> (6'd32 - prelen);
  end
  always @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      rx_hist <= 32'h0000_0000;
      rx_sh <= 8'h00;
      rx_cnt <= 3'd0;
      rx_sync <= 1'b0;
      rx_crc <= 32'h0000_0000;
      rx_byte <= 8'h00;
      rx_tag <= 2'b00;
      rx_byte_valid <= 1'b0;
      rx_overrun <= 1'b0;
      crc_ok <= 1'b0;
    end else begin
      if (rd && paddr == `RFM_RXDATA_OFF)
        rx_byte_valid <= 1'b0;
      if (wr && paddr == `RFM_STATUS_OFF && pwdata[2])
        rx_overrun <= 1'b0;
      if (!ctrl[`RFM_CTRL_RXEN_BIT] || (wr && paddr == `RFM_CTRL_OFF))
        rx_sync <= 1'b0;
      if (rx_bit_evt) begin
        rx_hist <= hist_next;
        rx_sh <= rx_next;
        rx_cnt <= rx_cnt + 1'b1;
        if (rx_sync && !raw)
          rx_crc <= crc_step(rx_crc, rx_bit, crc_kind); // RULE5
        case (frame_mode)
          `RFM_FRM_RAW: rx_sync <= 1'b1; // RULE7
          `RFM_FRM_RAWPM: begin
            if (!rx_sync && ((hist_next ^ preamble) & pre_mask) == 32'h0000_0000) begin
              rx_sync <= 1'b1; // RULE8
              rx_cnt <= 3'd0; // RULE8
            end
          end
          default: begin
            if (hist_next[7:0] == {`RFM_FLAG}) begin // RULE2
              if (rx_sync) begin
                rx_byte <= {7'h00, rx_crc == res_good}; // RULE5
                rx_tag <= 2'b10;
                crc_ok <= (rx_crc == res_good);
                rx_overrun <= rx_overrun | rx_byte_valid;
                rx_byte_valid <= 1'b1;
              end
              rx_sync <= 1'b1;
              rx_cnt <= 3'd0;
              rx_crc <= crc_init(crc_kind);
            end
          end
        endcase
        if (rx_sync && rx_cnt == 3'd7 && (raw || hist_next[7:0] != `RFM_FLAG)) begin
          rx_byte <= rx_next; // RULE5 RULE7
          rx_tag <= 2'b00;
          rx_overrun <= rx_overrun | rx_byte_valid;
          rx_byte_valid <= 1'b1;
        end
      end
    end
  end
  always @(posedge pclk or negedge presetn) begin
    if (!presetn)
      prdata <= 32'h0000_0000;
    else if (psel && !penable && !pwrite)
      prdata <= rdata;
  end
endmodule

// ==== verification/rfm_framer_sva.sv ====
// Checker for the framing block: register readback and modulator outputs.
// Assumes it is bound to rfm_framer and sees only its ports.
`timescale 1ns/1ps
`include "rfm_defines.vh"
module rfm_framer_sva (
  input wire pclk, // Bus clock
  input wire presetn, // Async reset, active low
  input wire psel, // APB select
  input wire penable, // APB enable
  input wire pwrite, // APB direction
  input wire [11:0] paddr, // APB byte address
  input wire [31:0] pwdata, // APB write data
  input wire [31:0] prdata, // APB read data
  input wire [7:0] gain_control_counter, // Gain counter
  input wire [7:0] filtered_strength_value, // Post-filter strength
  input wire [15:0] tracked_amplitude, // Amplitude
  input wire [31:0] carrier_offset_tracking, // Tracking word
  input wire [2:0] pa_phase_flip, // Phase toggle count
  input wire [1:0] freq_shape, // Shaping selection
  input wire tx_active // Transmitting
);
  reg [31:0] ctrl_seen;
  wire rd_acc = psel && penable && !pwrite;
  always @(posedge pclk or negedge presetn) begin
    if (!presetn)
      ctrl_seen <= `RFM_CTRL_RST;
    else if (psel && penable && pwrite && paddr == `RFM_CTRL_OFF)
      ctrl_seen <= pwdata;
  end
  default clocking cb @(posedge pclk); endclocking
  default disable iff (!presetn);
  property p_gain;
    rd_acc && paddr == `RFM_GAIN_OFF |-> prdata[7:0] == $past(gain_control_counter);
  endproperty
  a_gain: assert property (p_gain) else $error("gain");
  property p_synth;
    rd_acc && paddr == `RFM_GAIN_OFF |-> prdata[8] == ctrl_seen[13];
  endproperty
  a_synth: assert property (p_synth) else $error("synth");
  property p_strength;
    rd_acc && paddr == `RFM_STRENGTH_OFF |-> prdata[7:0] == $past(filtered_strength_value);
  endproperty
  a_strength: assert property (p_strength) else $error("strength");
  property p_ampl;
    rd_acc && paddr == `RFM_AMPL_OFF |-> prdata[15:0] == $past(tracked_amplitude);
  endproperty
  a_ampl: assert property (p_ampl) else $error("amplitude");
  property p_offset;
    rd_acc && paddr == `RFM_OFFSET_OFF |-> prdata == $past(carrier_offset_tracking);
  endproperty
  a_offset: assert property (p_offset) else $error("offset");
  property p_prelen;
    rd_acc && paddr == `RFM_PRELEN_OFF |-> prdata[5:0] >= 6'h04 && prdata[5:0] <= 6'h20;
  endproperty
  a_prelen: assert property (p_prelen) else $error("prelen");
  property p_fsk_shape;
    tx_active && $past(tx_active) && ctrl_seen[4:2] == `RFM_MOD_FSK
      |-> freq_shape == ctrl_seen[11:10];
  endproperty
  a_fsk_shape: assert property (p_fsk_shape) else $error("shape");
  property p_4fsk_hard;
    tx_active && $past(tx_active) && ctrl_seen[4:2] == `RFM_MOD_4FSK
      |-> freq_shape == `RFM_FSH_HARD;
  endproperty
  a_4fsk_hard: assert property (p_4fsk_hard) else $error("4fsk shape");
  property p_phase_step;
    $changed(pa_phase_flip) |-> pa_phase_flip == $past(pa_phase_flip) + 3'h1;
  endproperty
  a_phase_step: assert property (p_phase_step) else $error("phase jump");
endmodule
bind rfm_framer rfm_framer_sva u_sva (.pclk(pclk), .presetn(presetn), .psel(psel),
  .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata),
  .gain_control_counter(gain_control_counter),
  .filtered_strength_value(filtered_strength_value), .tracked_amplitude(tracked_amplitude),
  .carrier_offset_tracking(carrier_offset_tracking), .pa_phase_flip(pa_phase_flip),
  .freq_shape(freq_shape), .tx_active(tx_active));

// ==== verification/rfm_front_end.sv ====
// Model of the radio front end: bit stream with strobe and measurement levels.
// Assumes the strobe is slow against pclk so the synchroniser sees each bit.
`timescale 1ns/1ps
module rfm_front_end (
  output reg rx_bit_in, // Demodulated bit
  output reg rx_bit_strobe, // Bit strobe
  output reg [7:0] gain_control_counter, // Gain counter
  output reg [7:0] filtered_strength_value, // Post-filter strength
  output reg [15:0] tracked_amplitude, // Amplitude
  output reg [31:0] carrier_offset_tracking // Tracking word
);
  initial begin
    rx_bit_in = 1'b0;
    rx_bit_strobe = 1'b0;
    set_meas(8'h00, 8'h00, 16'h0000, 32'h0000_0000);
  end
  // LSB first; inverse on the line after the strobe
  task automatic send_bits(input [31:0] bits, input integer n);
    integer i;
    for (i = 0; i < n; i = i + 1) begin
      rx_bit_in = bits[i];
      #100 rx_bit_strobe = 1'b1;
      #200 rx_bit_strobe = 1'b0;
      rx_bit_in = ~bits[i];
      #100;
    end
  endtask
  task automatic set_meas(input [7:0] g, input [7:0] s, input [15:0] a, input [31:0] o);
    gain_control_counter = g;
    filtered_strength_value = s;
    tracked_amplitude = a;
    carrier_offset_tracking = o;
  endtask
endmodule

// ==== verification/tb.sv ====
// Testbench: register, receive and transmit sequences over APB.
// Assumes the front-end model drives all measurement and bit inputs.
`timescale 1ns/1ps
`include "rfm_defines.vh"
module tb;
  reg pclk = 1'b0;
  reg presetn = 1'b0;
  reg psel = 1'b0, penable = 1'b0, pwrite = 1'b0;
  reg [11:0] paddr = 12'h000;
  reg [31:0] pwdata = 32'h0000_0000;
  wire [31:0] prdata;
  wire pready, pslverr, rx_bit_in, rx_bit_strobe, pa_enable, tx_active;
  wire [7:0] gain_control_counter, filtered_strength_value, pa_amplitude;
  wire [15:0] tracked_amplitude;
  wire [31:0] carrier_offset_tracking;
  wire [2:0] pa_phase_flip;
  wire signed [17:0] freq_offset;
  wire [1:0] freq_shape;
  reg [31:0] rdat;
  reg rerr;
  integer err_total = 0;
  integer n_checks = 0;
  rfm_framer uut (.pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable),
    .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready),
    .pslverr(pslverr), .rx_bit_in(rx_bit_in), .rx_bit_strobe(rx_bit_strobe),
    .gain_control_counter(gain_control_counter),
    .filtered_strength_value(filtered_strength_value), .tracked_amplitude(tracked_amplitude),
    .carrier_offset_tracking(carrier_offset_tracking), .pa_enable(pa_enable),
    .pa_amplitude(pa_amplitude), .pa_phase_flip(pa_phase_flip), .freq_offset(freq_offset),
    .freq_shape(freq_shape), .tx_active(tx_active));
  rfm_front_end fe (.rx_bit_in(rx_bit_in), .rx_bit_strobe(rx_bit_strobe),
    .gain_control_counter(gain_control_counter),
    .filtered_strength_value(filtered_strength_value), .tracked_amplitude(tracked_amplitude),
    .carrier_offset_tracking(carrier_offset_tracking));
  initial forever #12.5 pclk = ~pclk;
  task automatic apb(input w, input [11:0] a, input [31:0] d);
    begin
      psel <= 1'b1;
      pwrite <= w;
      paddr <= a;
      pwdata <= d;
      @(posedge pclk);
      penable <= 1'b1;
      @(posedge pclk);
      while (pready !== 1'b1) @(posedge pclk);
      rdat = prdata;
      rerr = pslverr;
      psel <= 1'b0;
      penable <= 1'b0;
      @(posedge pclk);
    end
  endtask
  task automatic chk(input [95:0] nm, input [31:0] ex, input [31:0] got);
    n_checks = n_checks + 1;
    if (got !== ex) begin
      err_total = err_total + 1;
      $display("unexpected %0s expected %h seen %h", nm, ex, got);
    end
  endtask
  task automatic rd_chk(input [11:0] a, input [31:0] m, input [31:0] ex);
    apb(1'b0, a, 32'h0000_0000);
    chk("register", ex, rdat & m);
  endtask
  // Mid-bit checks of 16-cycle bits; raw mode starts one tick later
  task automatic tx_chk(input [15:0] ctl, input [7:0] b, input [7:0] ex);
    integer i;
    reg par;
    begin
      apb(1'b1, `RFM_CTRL_OFF, ctl);
      apb(1'b1, `RFM_TXDATA_OFF, {8'h01, b});
      while (tx_active !== 1'b1) @(posedge pclk);
      repeat (24) @(posedge pclk);
      par = pa_phase_flip[0];
      if (ctl[1]) repeat (16) @(posedge pclk);
      for (i = 0; i < 8; i = i + 1) begin
        par = par ^ ex[i];
        if (ctl[4:2] == `RFM_MOD_ASK) begin
          chk("pa_enable", ex[i], pa_enable);
        end else if (ctl[4:2] == `RFM_MOD_PSK) begin
          chk("phase", par, pa_phase_flip[0]);
        end else if (ctl[11:10] == `RFM_FSH_HARD && ctl[4:2] != `RFM_MOD_4FSK) begin
          chk("freq_sign", !ex[i], freq_offset[17]);
        end
        repeat (16) @(posedge pclk);
      end
      while (tx_active !== 1'b0) @(posedge pclk);
    end
  endtask
  task automatic final_report;
    if (err_total == 0 && n_checks > 0)
      $display("All checks passed");
    else
      $display("Checks failed");
    $finish;
  endtask
  initial begin
    #2000000;
    err_total = err_total + 1;
    final_report;
  end
  initial begin
    repeat (8) @(posedge pclk);
    presetn <= 1'b1;
    @(posedge pclk);
    rd_chk(`RFM_CTRL_OFF, 32'hFFFF_FFFF, 32'h0000_0200);
    rd_chk(`RFM_RATE_OFF, 32'h0000_FFFF, 32'h0000_0140);
    rd_chk(`RFM_PRELEN_OFF, 32'h0000_003F, 32'h0000_0010);
    apb(1'b0, 12'h040, 32'h0000_0000);
    chk("pslverr", 1, rerr);
    apb(1'b1, `RFM_PRELEN_OFF, 8'h02);
    rd_chk(`RFM_PRELEN_OFF, 32'h0000_003F, 32'h0000_0004);
    apb(1'b1, `RFM_PRELEN_OFF, 8'h28);
    rd_chk(`RFM_PRELEN_OFF, 32'h0000_003F, 32'h0000_0020);
    fe.set_meas(8'h5A, 8'hC3, 16'hBEEF, 32'h1234_5678);
    apb(1'b1, `RFM_CTRL_OFF, 16'h2200);
    rd_chk(`RFM_GAIN_OFF, 32'h0000_01FF, 32'h0000_015A);
    rd_chk(`RFM_STRENGTH_OFF, 32'h0000_00FF, 32'h0000_00C3);
    rd_chk(`RFM_AMPL_OFF, 32'h0000_FFFF, 32'h0000_BEEF);
    rd_chk(`RFM_OFFSET_OFF, 32'hFFFF_FFFF, 32'h1234_5678);
    apb(1'b1, `RFM_CTRL_OFF, 16'h1202);
    fe.send_bits(32'h0000_00A5, 8);
    repeat (10) @(posedge pclk);
    rd_chk(`RFM_RXDATA_OFF, 32'h0000_04FF, 32'h0000_04A5);
    rd_chk(`RFM_RXDATA_OFF, 32'h0000_0400, 32'h0000_0000);
    apb(1'b1, `RFM_PREAMBLE_OFF, 8'h81);
    apb(1'b1, `RFM_PRELEN_OFF, 8'h08);
    apb(1'b1, `RFM_CTRL_OFF, 16'h1203);
    fe.send_bits(32'h0000_0000, 5);
    fe.send_bits(32'h0000_0081, 8);
    repeat (10) @(posedge pclk);
    rd_chk(`RFM_RXDATA_OFF, 32'h0000_0400, 32'h0000_0000);
    fe.send_bits(32'h0000_003C, 8);
    repeat (10) @(posedge pclk);
    rd_chk(`RFM_RXDATA_OFF, 32'h0000_04FF, 32'h0000_043C);
    apb(1'b1, `RFM_RATE_OFF, 16'h0010);
    apb(1'b1, `RFM_DEV_OFF, 16'h0100);
    tx_chk(16'h0002, 8'hB3, 8'hB3);
    tx_chk(16'h0000, 8'h00, `RFM_FLAG);
    tx_chk(16'h0206, 8'h5C, 8'h5C);
    tx_chk(16'h020A, 8'h96, 8'h96);
    tx_chk(16'h020E, 8'hD1, 8'hD1);
    tx_chk(16'h0606, 8'h11, 8'h11);
    tx_chk(16'h0A12, 8'h2D, 8'h2D);
    final_report;
  end
endmodule
